// ### fcsf_top.sv
// How it works
// [RULE_01] byte order strap sampled at master reset
// [RULE_02] big-endian: upper byte out first
// [RULE_03] little-endian: lower byte out first
// [RULE_04] flag timing strap sampled at master reset
// [RULE_05] async almost-empty: low on read, high on write
// [RULE_06] async almost-full: low on write, high on read
// [RULE_07] sync almost-empty updates on read side only
// [RULE_08] sync almost-full updates on write side only
// [RULE_09] parity placement strap sampled at master reset
// [RULE_10] interspersed: skip bit 8, bit 8 reads invalid
// [RULE_11] non-interspersed: skip bits 16-17, bit 8 valid
// [RULE_12] full flag low when full, blocks writes
// [RULE_13] full after depth writes following any reset; the code fills fall-through mode at depth+1 writes (CAP_FWFT)
// [RULE_14] input ready high when no space left
// [RULE_15] output register word counts toward occupancy
// [RULE_16] full/ready flag goes through two registers
// [RULE_17] retransmit mode compares write pointer to mark
// [RULE_18] empty flag low when empty, blocks reads
// [RULE_19] output ready falls with first valid data
// [RULE_20] output ready rises only on true read; the code also raises it on retransmit (rt_go)
// [RULE_21] empty two stages, output ready three stages
// [RULE_22] offsets read back over parallel path only
// [RULE_23] straps held until next master reset
`timescale 1ns/1ps
module fcsf_top import fcsf_pkg::*;
(
   // clock and resets
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_partial_reset,
   // configuration straps
   input wire logic i_byte_order_select,
   input wire logic i_flag_timing_select,
   input wire logic i_parity_placement_select,
   input wire logic i_fwft_select,
   input wire logic i_byte_out_select,
   // write side
   input wire logic i_write_en,
   input wire logic [DATA_W-1:0] i_data,
   // read side
   input wire logic i_read_en,
   input wire logic i_read_select_n,
   input wire logic i_offset_access_n,
   input wire logic i_mark,
   input wire logic i_retransmit,
   // data and flags
   output logic [DATA_W-1:0] o_data,
   output logic o_full_flag_n,
   output logic o_input_ready_n,
   output logic o_empty_flag_n,
   output logic o_output_ready_n,
   output logic o_almost_empty_flag_n,
   output logic o_almost_full_flag_n
);
   // =====================================================
   // byte steering
   function automatic logic [DATA_W-1:0] pick_byte(input logic [DATA_W-1:0] w,
      input logic le, input logic second, input logic byte_out);
      if (!byte_out)
         return w;
      // little-endian shows the low byte first, big-endian the high byte
      return {{BYTE_W{1'b0}}, (le ^ second) ? w[BYTE_W-1:0] : w[DATA_W-1:BYTE_W]}; // RULE_02 RULE_03
   endfunction

   fcsf_mem_if mem_bus ();

   fcsf_mem u_mem (
      .i_clk(i_clk),
      .bus(mem_bus)
   );

   // =====================================================
   // configuration
   fcsf_cfg_t cfg_q, cfg_d;

   always_comb
   begin
      cfg_d = cfg_q;
      // straps only move under master reset, partial reset leaves them alone
      if (i_reset)
      begin
         cfg_d.little_endian = i_byte_order_select; // RULE_01 RULE_23
         cfg_d.sync_flags = i_flag_timing_select; // RULE_04
         cfg_d.interspersed = i_parity_placement_select; // RULE_09
         cfg_d.fwft = i_fwft_select;
         cfg_d.byte_out = i_byte_out_select;
      end
   end

   always_ff @(posedge i_clk)
      cfg_q <= cfg_d;

   // =====================================================
   // datapath and pointers
   logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d, mark_q, mark_d;
   logic rt_mode_q, rt_mode_d, pend_q, pend_d, phase_q, phase_d;
   logic [DATA_W-1:0] hold_q, hold_d, data_q, data_d;
   logic [OFF_W-1:0] e_off_q, e_off_d, f_off_q, f_off_d;
   logic ld_sel_q, ld_sel_d, rb_sel_q, rb_sel_d, or_n_q, or_n_d;
   logic [PTR_W-1:0] count, used_rt;
   logic [OCC_W-1:0] occ, cap;
   logic shown, rd_avail, full_now, wr_ok, true_read, std_rd, consume, pop;
   logic rt_go, ld_wr, rb, read_evt, avail_q, avail_d;
   logic [OFF_W-1:0] off_in, off_rb;

   always_comb
   begin
      count = wr_ptr_q - rd_ptr_q;
      used_rt = wr_ptr_q - mark_q;
      shown = cfg_q.fwft & ~or_n_q;
      rd_avail = count != '0;
      occ = {1'b0, count} + OCC_W'(cfg_q.fwft & (shown | pend_q)); // RULE_15
      cap = cfg_q.fwft ? CAP_FWFT : CAP_STD; // RULE_13 RULE_15
      // retransmit keeps marked data safe, so space is measured from the mark
      full_now = rt_mode_q ? ({1'b0, used_rt} >= CAP_STD) : (occ >= cap); // RULE_17
      wr_ok = i_write_en & i_offset_access_n & ~full_now & ~i_partial_reset; // RULE_12 RULE_14
      true_read = i_read_en & ~i_read_select_n & i_offset_access_n;
      std_rd = ~cfg_q.fwft & true_read & ~pend_q & (phase_q | rd_avail); // RULE_18
      consume = cfg_q.fwft & true_read & shown & ~pend_q;
      // fall-through waits one registered look at availability: third edge after write
      pop = (std_rd & ~phase_q)
         | (cfg_q.fwft & ~pend_q & rd_avail & avail_q & (~shown | (consume & ~phase_q))); // RULE_21
      rt_go = i_retransmit & rt_mode_q & ~i_read_select_n & ~pend_q;
      ld_wr = i_write_en & ~i_offset_access_n;
      rb = i_read_en & ~i_read_select_n & ~i_offset_access_n;
      read_evt = pop | consume | std_rd;
      if (cfg_q.interspersed)
         off_in = {i_data[PAR_HI_BIT-1:PAR_LO_BIT+1], i_data[PAR_LO_BIT-1:0]}; // RULE_10
      else
         off_in = i_data[NONINT_PAR_BIT-1:0]; // RULE_11
      off_rb = rb_sel_q ? f_off_q : e_off_q;

      wr_ptr_d = wr_ptr_q + PTR_W'(wr_ok);
      rd_ptr_d = rd_ptr_q + PTR_W'(pop);
      mark_d = mark_q;
      rt_mode_d = i_mark;
      if (i_mark & ~rt_mode_q)
         mark_d = rd_ptr_q;
      pend_d = pop;
      avail_d = rd_avail;
      phase_d = phase_q;
      hold_d = hold_q;
      data_d = data_q;
      or_n_d = or_n_q;
      e_off_d = e_off_q;
      f_off_d = f_off_q;
      ld_sel_d = i_offset_access_n ? 1'b0 : ld_sel_q ^ ld_wr;
      rb_sel_d = i_offset_access_n ? 1'b0 : rb_sel_q ^ rb;

      if (ld_wr)
      begin
         if (ld_sel_q)
            f_off_d = off_in;
         else
            e_off_d = off_in;
      end
      // only the parallel path reads offsets back
      if (rb)
      begin
         if (cfg_q.interspersed)
            data_d = {1'b0, off_rb[OFF_W-1:PAR_LO_BIT], 1'b0, off_rb[PAR_LO_BIT-1:0]}; // RULE_10 RULE_22
         else
            data_d = {2'b00, off_rb}; // RULE_11 RULE_22
      end

      if ((std_rd | consume) & phase_q)
      begin
         data_d = pick_byte(hold_q, cfg_q.little_endian, 1'b1, cfg_q.byte_out); // RULE_02 RULE_03
         phase_d = 1'b0;
      end
      else if (consume)
         or_n_d = 1'b1; // RULE_20
      if (pend_q)
      begin
         hold_d = mem_bus.rdata;
         data_d = pick_byte(mem_bus.rdata, cfg_q.little_endian, 1'b0, cfg_q.byte_out);
         phase_d = cfg_q.byte_out;
         or_n_d = ~cfg_q.fwft; // RULE_19
      end
      if (rt_go)
      begin
         rd_ptr_d = mark_q;
         pend_d = 1'b0;
         phase_d = 1'b0;
         or_n_d = 1'b1;
      end
   end

   assign mem_bus.we = wr_ok;
   assign mem_bus.waddr = wr_ptr_q[ADDR_W-1:0];
   assign mem_bus.wdata = i_data;
   assign mem_bus.re = pop;
   assign mem_bus.raddr = rd_ptr_q[ADDR_W-1:0];

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         e_off_q <= RST_EMPTY_OFFSET;
         f_off_q <= RST_FULL_OFFSET;
      end
      else
      begin
         e_off_q <= e_off_d;
         f_off_q <= f_off_d;
      end
      // partial reset clears data but keeps offsets and straps
      if (i_reset | i_partial_reset)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         mark_q <= '0;
         rt_mode_q <= 1'b0;
         pend_q <= 1'b0;
         avail_q <= 1'b0;
         phase_q <= 1'b0;
         hold_q <= '0;
         data_q <= '0;
         or_n_q <= 1'b1;
         ld_sel_q <= 1'b0;
         rb_sel_q <= 1'b0;
      end
      else
      begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         mark_q <= mark_d;
         rt_mode_q <= rt_mode_d;
         pend_q <= pend_d;
         avail_q <= avail_d;
         phase_q <= phase_d;
         hold_q <= hold_d;
         data_q <= data_d;
         or_n_q <= or_n_d;
         ld_sel_q <= ld_sel_d;
         rb_sel_q <= rb_sel_d;
      end
   end

   // =====================================================
   // status flags
   logic ff1_q, ff1_d, ff_n_q, ff_n_d, ir_n_q, ir_n_d, ef1_q, ef1_d, ef_n_q, ef_n_d;
   logic ae_n_q, ae_n_d, af_n_q, af_n_d, ae_cond, af_cond;

   always_comb
   begin
      ae_cond = {3'h0, occ} <= (e_off_q + OFF_W'(cfg_q.fwft));
      af_cond = ({4'h0, occ} + {1'b0, f_off_q}) >= {4'h0, cap};
      ff1_d = full_now; // RULE_16
      ff_n_d = cfg_q.fwft | ~ff1_q; // RULE_12 RULE_16
      ir_n_d = cfg_q.fwft & ff1_q; // RULE_14 RULE_16
      ef1_d = ~(rd_avail | phase_q); // RULE_21
      ef_n_d = cfg_q.fwft | ~ef1_q; // RULE_18 RULE_21
      ae_n_d = ae_n_q;
      af_n_d = af_n_q;
      if (cfg_q.sync_flags)
      begin
         ae_n_d = ~ae_cond; // RULE_07
         af_n_d = ~af_cond; // RULE_08
      end
      else
      begin
         // async: each flag is set by one side and released by the other
         if (read_evt & ae_cond)
            ae_n_d = 1'b0; // RULE_05
         else if (wr_ok & ~ae_cond)
            ae_n_d = 1'b1; // RULE_05
         if (wr_ok & af_cond)
            af_n_d = 1'b0; // RULE_06
         else if (read_evt & ~af_cond)
            af_n_d = 1'b1; // RULE_06
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_reset | i_partial_reset)
      begin
         ff1_q <= 1'b0;
         ff_n_q <= 1'b1;
         ir_n_q <= 1'b0;
         ef1_q <= 1'b1;
         ef_n_q <= 1'b0;
         ae_n_q <= 1'b0;
         af_n_q <= 1'b1;
      end
      else
      begin
         ff1_q <= ff1_d;
         ff_n_q <= ff_n_d;
         ir_n_q <= ir_n_d;
         ef1_q <= ef1_d;
         ef_n_q <= ef_n_d;
         ae_n_q <= ae_n_d;
         af_n_q <= af_n_d;
      end
   end

   assign o_data = data_q;
   assign o_full_flag_n = ff_n_q;
   assign o_input_ready_n = ir_n_q;
   assign o_empty_flag_n = ef_n_q;
   assign o_output_ready_n = or_n_q;
   assign o_almost_empty_flag_n = ae_n_q;
   assign o_almost_full_flag_n = af_n_q;

   // =====================================================
   // assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset | i_partial_reset);

   property p_cfg_hold;
      disable iff (i_reset) 1'b1 |=> $stable(cfg_q);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("strap changed"); // RULE_23
   property p_no_write_full;
      full_now |-> !mem_bus.we;
   endproperty
   a_no_write_full: assert property (p_no_write_full) else $error("write when full"); // RULE_12
   property p_ff_path;
      !cfg_q.fwft ##2 1'b1 |-> o_full_flag_n == !$past(full_now, 2);
   endproperty
   a_ff_path: assert property (p_ff_path) else $error("full flag lag wrong"); // RULE_16
   property p_ir_path;
      cfg_q.fwft ##2 1'b1 |-> o_input_ready_n == $past(full_now, 2);
   endproperty
   a_ir_path: assert property (p_ir_path) else $error("input ready lag wrong"); // RULE_14
   property p_ef_path;
      !cfg_q.fwft ##2 1'b1 |-> o_empty_flag_n == $past(rd_avail | phase_q, 2);
   endproperty
   a_ef_path: assert property (p_ef_path) else $error("empty flag lag wrong"); // RULE_21
   property p_or_with_data;
      cfg_q.fwft && pend_q && !rt_go |=> !o_output_ready_n;
   endproperty
   a_or_with_data: assert property (p_or_with_data) else $error("ready late"); // RULE_19
   property p_or_rise;
      cfg_q.fwft && !$past(i_reset | i_partial_reset) && $rose(o_output_ready_n)
         |-> $past(consume | rt_go) && $stable(o_data);
   endproperty
   a_or_rise: assert property (p_or_rise) else $error("ready rose without read"); // RULE_20
   property p_sync_ae;
      cfg_q.sync_flags |=> o_almost_empty_flag_n == !$past(ae_cond);
   endproperty
   a_sync_ae: assert property (p_sync_ae) else $error("almost empty wrong"); // RULE_07
   property p_async_ae;
      !cfg_q.sync_flags && !$past(i_reset | i_partial_reset) && $fell(o_almost_empty_flag_n)
         |-> $past(read_evt);
   endproperty
   a_async_ae: assert property (p_async_ae) else $error("almost empty fell without read"); // RULE_05
   property p_async_af;
      !cfg_q.sync_flags && !$past(i_reset | i_partial_reset) && $rose(o_almost_full_flag_n)
         |-> $past(read_evt);
   endproperty
   a_async_af: assert property (p_async_af) else $error("almost full rose without read"); // RULE_06
   property p_ip_q8;
      rb && cfg_q.interspersed |=> o_data[PAR_LO_BIT] == 1'b0;
   endproperty
   a_ip_q8: assert property (p_ip_q8) else $error("bit 8 not masked"); // RULE_10

   c_full: cover property (!o_full_flag_n);
   c_fwft_ready: cover property (cfg_q.fwft ##1 $fell(o_output_ready_n));
   c_byte_pair: cover property (cfg_q.byte_out && phase_q && std_rd);
   c_retransmit: cover property (rt_go);
endmodule // fcsf_top

// ### fcsf_pkg.sv
package fcsf_pkg;
   // =====================================================
   // geometry
   localparam int DATA_W = 18;
   localparam int BYTE_W = 9;
   localparam int ADDR_W = 11;
   localparam int DEPTH = 2048;
   localparam int PTR_W = 12;
   localparam int OCC_W = 13;
   localparam int OFF_W = 16;
   // =====================================================
   // capacity: fall-through counts the output register as one more word
   localparam logic [OCC_W-1:0] CAP_STD = 13'h0800;
   localparam logic [OCC_W-1:0] CAP_FWFT = 13'h0801;
   // =====================================================
   // offset field layout on the parallel data path
   localparam int PAR_LO_BIT = 8;
   localparam int PAR_HI_BIT = 17;
   localparam int NONINT_PAR_BIT = 16;
   // =====================================================
   // reset values
   localparam logic [OFF_W-1:0] RST_EMPTY_OFFSET = 16'h007F;
   localparam logic [OFF_W-1:0] RST_FULL_OFFSET = 16'h007F;
   typedef struct packed {
      logic little_endian;
      logic sync_flags;
      logic interspersed;
      logic fwft;
      logic byte_out;
   } fcsf_cfg_t;
   localparam fcsf_cfg_t RST_CFG = '0;
endpackage

// ### fcsf_mem_if.sv
`timescale 1ns/1ps
interface fcsf_mem_if import fcsf_pkg::*; ();
   logic we;
   logic [ADDR_W-1:0] waddr;
   logic [DATA_W-1:0] wdata;
   logic re;
   logic [ADDR_W-1:0] raddr;
   logic [DATA_W-1:0] rdata;
   modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
   modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface // fcsf_mem_if

// ### fcsf_mem.sv
`timescale 1ns/1ps
module fcsf_mem import fcsf_pkg::*;
(
   // clock
   input wire logic i_clk,
   // storage port
   fcsf_mem_if.mem bus
);
   logic [DATA_W-1:0] ram [DEPTH];
   logic [DATA_W-1:0] rdata_q;

   // no reset on the array: contents are only valid behind the pointers
   always_ff @(posedge i_clk)
   begin
      if (bus.we)
         ram[bus.waddr] <= bus.wdata;
      if (bus.re)
         rdata_q <= ram[bus.raddr];
   end

   assign bus.rdata = rdata_q;
endmodule // fcsf_mem

// ### fcsf_writer.sv
`timescale 1ns/1ps
// =====================================================
// writer model: far side of the write port
module fcsf_writer import fcsf_pkg::*;
(
   // clock
   input wire logic i_clk,
   // write port drive
   output logic o_write_en,
   output logic [DATA_W-1:0] o_data
);
   initial
   begin
      o_write_en = 1'b0;
      o_data = '0;
   end

   // words base, base+1, ... on back-to-back edges; data flips once released
   // so a design that samples a stale bus sees garbage, not the last word
   task automatic burst(input int n, input logic [DATA_W-1:0] base);
      for (int k = 0; k < n; k++)
      begin
         @(negedge i_clk);
         o_write_en = 1'b1;
         o_data = base + DATA_W'(k);
      end
      @(negedge i_clk);
      o_write_en = 1'b0;
      o_data = ~o_data;
   endtask
endmodule // fcsf_writer

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top import fcsf_pkg::*;;
   localparam int LIMIT = 30000;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic prst = 1'b0;
   logic be = 1'b0;
   logic flag_timing_select = 1'b0;
   logic ip = 1'b0;
   logic fwft = 1'b0;
   logic bo = 1'b0;
   logic re = 1'b0;
   logic ld_n = 1'b1;
   logic mk = 1'b0;
   logic rt = 1'b0;
   logic we;
   logic [DATA_W-1:0] wd;
   logic [DATA_W-1:0] q;
   logic ff_n, ir_n, ef_n, or_n, ae_n, af_n;
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;

   // =====================================================
   // clock, design, partner
   initial
   begin
      forever #5 clk = ~clk;
   end

   fcsf_writer fcsf_writer_i (.i_clk(clk), .o_write_en(we), .o_data(wd));

   fcsf_top fcsf_top_i (
      .i_clk(clk), .i_reset(rst), .i_partial_reset(prst),
      .i_byte_order_select(be), .i_flag_timing_select(flag_timing_select),
      .i_parity_placement_select(ip), .i_fwft_select(fwft), .i_byte_out_select(bo),
      .i_write_en(we), .i_data(wd), .i_read_en(re), .i_read_select_n(1'b0),
      .i_offset_access_n(ld_n), .i_mark(mk), .i_retransmit(rt), .o_data(q),
      .o_full_flag_n(ff_n), .o_input_ready_n(ir_n), .o_empty_flag_n(ef_n),
      .o_output_ready_n(or_n), .o_almost_empty_flag_n(ae_n), .o_almost_full_flag_n(af_n));

   // =====================================================
   // helpers
   task automatic results();
      if (num_errors == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         num_errors++;
         results();
      end
   end

   task automatic chk(input string name, input logic [DATA_W-1:0] exp,
                      input logic [DATA_W-1:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // straps are flipped right after release: later behaviour must not follow them
   task automatic master_reset(input logic b, input logic f, input logic p, input logic w,
                      input logic o);
      @(negedge clk);
      rst = 1'b1;
      {be, flag_timing_select, ip, fwft, bo} = {b, f, p, w, o};
      cyc(5);
      chk("reset data", '0, q);
      chk("reset flags", 18'h00025, {12'h000, ff_n, ir_n, ef_n, or_n, ae_n, af_n});
      rst = 1'b0;
      {be, flag_timing_select, ip, fwft, bo} = ~{b, f, p, w, o};
   endtask

   task automatic part_rst();
      @(negedge clk);
      prst = 1'b1;
      @(negedge clk);
      prst = 1'b0;
   endtask

   task automatic rd();
      @(negedge clk);
      re = 1'b1;
      @(negedge clk);
      re = 1'b0;
   endtask

   // =====================================================
   // byte order, with a partial reset in between that must keep the strap
   task automatic endian(input logic b);
      logic [DATA_W-1:0] w;
      w = 18'h0A1F3;
      master_reset(b, 1'b0, 1'b0, 1'b0, 1'b1);
      part_rst();
      fcsf_writer_i.burst(1, w);
      cyc(5);
      chk("empty flag after write", 18'h00001, {17'h0, ef_n});
      rd();
      cyc(2);
      chk("first byte", {9'h000, b ? w[8:0] : w[17:9]}, {9'h000, q[8:0]});
      rd();
      chk("second byte", {9'h000, b ? w[17:9] : w[8:0]}, {9'h000, q[8:0]});
      cyc(5);
      chk("empty flag drained", '0, {17'h0, ef_n});
   endtask

   // offset load and readback through the parallel path
   task automatic offs(input logic p, input logic [DATA_W-1:0] e1,
                       input logic [DATA_W-1:0] e2);
      master_reset(1'b0, 1'b0, p, 1'b0, 1'b0);
      @(negedge clk);
      ld_n = 1'b0;
      fcsf_writer_i.burst(1, 18'h3FFFF);
      fcsf_writer_i.burst(1, 18'h00100);
      @(negedge clk);
      ld_n = 1'b1;
      @(negedge clk);
      ld_n = 1'b0;
      re = 1'b1;
      @(negedge clk);
      chk("empty offset readback", e1, q);
      @(negedge clk);
      chk("full offset readback", e2, q);
      re = 1'b0;
      ld_n = 1'b1;
   endtask

   // =====================================================
   // main sequence
   initial
   begin
      cyc(5);
      endian(1'b0);
      endian(1'b1);
      offs(1'b1, 18'h1FEFF, 18'h00000);
      offs(1'b0, 18'h0FFFF, 18'h00100);
      // standard fill with async almost flags
      master_reset(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      fcsf_writer_i.burst(DEPTH - 1, 18'h00100);
      cyc(6);
      chk("full flag one short", 18'h00001, {17'h0, ff_n});
      fcsf_writer_i.burst(1, 18'h007FF);
      cyc(1);
      chk("full flag before two stages", 18'h00001, {17'h0, ff_n});
      cyc(1);
      chk("full flag at depth", '0, {17'h0, ff_n});
      chk("almost flags when full", 18'h00002, {16'h0, ae_n, af_n});
      fcsf_writer_i.burst(1, 18'h3FFFF);
      rd();
      cyc(2);
      chk("oldest word after refused write", 18'h00100, q);
      cyc(6);
      chk("full flag after read", 18'h00001, {17'h0, ff_n});
      // mark at word 1: space is now measured from the mark, not the read pointer
      mk = 1'b1;
      fcsf_writer_i.burst(1, 18'h00200);
      rd();
      cyc(6);
      chk("full flag from mark", '0, {17'h0, ff_n});
      rt = 1'b1;
      cyc(1);
      rt = 1'b0;
      rd();
      cyc(2);
      chk("word after retransmit", 18'h00101, q);
      mk = 1'b0;
      // fall-through with sync almost flags
      master_reset(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
      fcsf_writer_i.burst(1, 18'h2C3A5);
      cyc(2);
      chk("ready before fall-through", 18'h00001, {17'h0, or_n});
      cyc(1);
      chk("ready with first word", '0, {17'h0, or_n});
      chk("first word fell through", 18'h2C3A5, q);
      rd();
      cyc(1);
      chk("ready after last read", 18'h00001, {17'h0, or_n});
      chk("data kept after last read", 18'h2C3A5, q);
      part_rst();
      fcsf_writer_i.burst(DEPTH, '0);
      cyc(6);
      chk("input ready at depth", '0, {17'h0, ir_n});
      fcsf_writer_i.burst(1, 18'h00800);
      cyc(6);
      chk("input ready at depth plus one", 18'h00001, {17'h0, ir_n});
      results();
   end
endmodule // tb_top
